// *** rtl/opl_map.vh ***
// Register indices, field positions, reset values and codes for protection and limit logic
`ifndef OPL_MAP_VH
`define OPL_MAP_VH

// ----------------------------------------------------------------------------
// Register select codes
// ----------------------------------------------------------------------------
`define OPL_SEL_CURR_PROT    3'h0
`define OPL_SEL_VOLT_PROT    3'h1
`define OPL_SEL_OFF_CURR     3'h2
`define OPL_SEL_OFF_VOLT     3'h3
`define OPL_SEL_ON_CURR      3'h4
`define OPL_SEL_ON_VOLT      3'h5
`define OPL_SEL_OFF_CTRL     3'h6
`define OPL_SEL_LAST         3'h6

// ----------------------------------------------------------------------------
// Protection control bit positions
// ----------------------------------------------------------------------------
`define OPL_B_FIXED_LIMIT    7
`define OPL_B_DETECT_EN      6
`define OPL_B_ESR_EN         5
`define OPL_B_ESE_INIT       4
`define OPL_B_QUEUE_ERR      3
`define OPL_B_PROT_OFF       2
`define OPL_B_MEAS_MSG       1
`define OPL_B_MEAS_OFF       0

// ----------------------------------------------------------------------------
// Output-off limit control bit positions
// ----------------------------------------------------------------------------
`define OPL_O_VOLT_MAX       0
`define OPL_O_CURR_MAX       1
`define OPL_O_VOLT_CODE      2
`define OPL_O_CURR_CODE      3
`define OPL_O_CURR_CODE_EN   4
`define OPL_O_VOLT_CODE_EN   3

// ----------------------------------------------------------------------------
// Reset values and constants
// ----------------------------------------------------------------------------
`define OPL_RST_PROT         8'h00
`define OPL_RST_OFF_CTRL     5'h00
`define OPL_RST_CURR_CODE    8'h80
`define OPL_RST_VOLT_CODE    8'h00
`define OPL_DAC_ZERO         8'h00
`define OPL_DAC_MAX          8'hFF
`define OPL_ESE_WITH_CP      8'h48
`define OPL_ESE_PLAIN        8'h08
`define OPL_ESE_CP_BIT       3
`define OPL_ERR_CURR_PROT    10'h12F
`define OPL_ERR_VOLT_PROT    10'h130
`define OPL_ERR_NONE         10'h000

`endif

// *** rtl/opl_regfile.v ***
// Small register store for protection and limit settings with registered read
`timescale 1ns/1ps
module opl_regfile
(
    // Clock and reset
    input  wire       clk,
    input  wire       sys_rst,
    // Write and read access
    input  wire       wr_en,
    input  wire [2:0] wr_sel,
    input  wire [7:0] wr_data,
    input  wire [2:0] rd_sel,
    output reg  [7:0] rd_data,
    // Continuous contents
    output reg  [7:0] curr_prot_reg,
    output reg  [7:0] volt_prot_reg,
    output reg  [7:0] off_curr_reg,
    output reg  [7:0] off_volt_reg,
    output reg  [7:0] on_curr_reg,
    output reg  [7:0] on_volt_reg,
    output reg  [4:0] off_ctrl_reg
);
`include "opl_map.vh"

    // ------------------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------------------
    // Writes land on the next edge; all fields always visible
    always @(posedge clk)
    begin
        if (sys_rst)
        begin
            curr_prot_reg <= `OPL_RST_PROT;
            volt_prot_reg <= `OPL_RST_PROT;
            off_curr_reg  <= `OPL_RST_CURR_CODE;
            off_volt_reg  <= `OPL_RST_VOLT_CODE;
            on_curr_reg   <= `OPL_RST_CURR_CODE;
            on_volt_reg   <= `OPL_RST_VOLT_CODE;
            off_ctrl_reg  <= `OPL_RST_OFF_CTRL;
        end
        else if (wr_en)
        begin
            case (wr_sel)
                `OPL_SEL_CURR_PROT: curr_prot_reg <= wr_data;
                `OPL_SEL_VOLT_PROT: volt_prot_reg <= wr_data;
                `OPL_SEL_OFF_CURR:  off_curr_reg  <= wr_data;
                `OPL_SEL_OFF_VOLT:  off_volt_reg  <= wr_data;
                `OPL_SEL_ON_CURR:   on_curr_reg   <= wr_data;
                `OPL_SEL_ON_VOLT:   on_volt_reg   <= wr_data;
                `OPL_SEL_OFF_CTRL:  off_ctrl_reg  <= wr_data[4:0];
                default:            off_ctrl_reg  <= off_ctrl_reg;
            endcase
        end
    end

    // ------------------------------------------------------------------------
    // Registered read port
    // ------------------------------------------------------------------------
    // Read-back of each setting byte
    always @(posedge clk)
    begin
        if (sys_rst)
            rd_data <= 8'h00;
        else
        begin
            case (rd_sel)
                `OPL_SEL_CURR_PROT: rd_data <= curr_prot_reg;
                `OPL_SEL_VOLT_PROT: rd_data <= volt_prot_reg;
                `OPL_SEL_OFF_CURR:  rd_data <= off_curr_reg;
                `OPL_SEL_OFF_VOLT:  rd_data <= off_volt_reg;
                `OPL_SEL_ON_CURR:   rd_data <= on_curr_reg;
                `OPL_SEL_ON_VOLT:   rd_data <= on_volt_reg;
                `OPL_SEL_OFF_CTRL:  rd_data <= {3'h0, off_ctrl_reg};
                default:            rd_data <= 8'h00;
            endcase
        end
    end

endmodule

// *** rtl/opl_protect.v ***
// Protection control, limit DAC selection and error reaction for the output stage
`timescale 1ns/1ps
// Contract
// - Accept an 8-bit current protection control byte, 00 to FF.
// - Current bit 7: fixed current limit level while output is on.
// - Current bit 6 enables current protection error detection.
// - Current bit 5 enables the current-protect bit in status/enable registers.
// - Current bit 4: event enable resets to 72 if bit 5, else 8.
// - Current bit 3: current protect error queues error 303.
// - Current bit 2: current protect error switches output off.
// - Current bit 1: current measurement error in current mode gives device error.
// - Current bit 0: current measurement error in current mode shuts unit down.
// - Current control read-back returns one byte.
// - Accept voltage control byte; bit 7 fixes voltage limit while output on.
// - Voltage bit 6 enables voltage protection error detection.
// - Voltage bit 3: voltage protect error queues error 304.
// - Voltage bit 2: voltage protect error switches output off.
// - Voltage bit 1: voltage measurement error in voltage mode gives device error.
// - Voltage bit 0: that voltage device error also switches output off.
// - Off current code used when off, voltage mode, off-control bit 4.
// - Off voltage code used when off, current mode, off-control bit 3.
// - On current code used when on, voltage mode, current bit 7.
// - On voltage code used when on, current mode, voltage bit 7.
// - Off-control bit 0/1 force voltage/current limit maximum in voltage/current mode; zero gives zero.
module opl_protect
(
    // Clock and reset
    input  wire       clk,
    input  wire       sys_rst,
    // Setting access from the command layer
    input  wire       cfg_wr,
    input  wire [2:0] cfg_sel,
    input  wire [7:0] cfg_wdata,
    input  wire [2:0] cfg_rsel,
    output wire [7:0] cfg_rdata,
    // Output stage state
    input  wire       output_on,
    input  wire       current_mode,
    // Detected conditions
    input  wire       curr_prot_hit,
    input  wire       volt_prot_hit,
    input  wire       curr_meas_err,
    input  wire       volt_meas_err,
    // Event status handling
    input  wire       esr_clear,
    input  wire       ese_load,
    output reg  [7:0] ese_reset_value,
    output reg        esr_curr_prot,
    output reg        esr_cp_enabled,
    // Error queue and reactions
    output reg        err_push,
    output reg  [9:0] err_code,
    output reg        dev_err_push,
    output reg        force_off,
    output reg        shutdown,
    // Limit DAC codes
    output reg  [7:0] curr_limit_dac,
    output reg  [7:0] volt_limit_dac
);
`include "opl_map.vh"

    // ------------------------------------------------------------------------
    // Setting storage
    // ------------------------------------------------------------------------
    wire [7:0] curr_prot_reg;
    wire [7:0] volt_prot_reg;
    wire [7:0] off_curr_reg;
    wire [7:0] off_volt_reg;
    wire [7:0] on_curr_reg;
    wire [7:0] on_volt_reg;
    wire [4:0] off_ctrl_reg;

    opl_regfile u_regs
    (
        .clk           (clk),
        .sys_rst       (sys_rst),
        .wr_en         (cfg_wr),
        .wr_sel        (cfg_sel),
        .wr_data       (cfg_wdata),
        .rd_sel        (cfg_rsel),
        .rd_data       (cfg_rdata),
        .curr_prot_reg (curr_prot_reg),
        .volt_prot_reg (volt_prot_reg),
        .off_curr_reg  (off_curr_reg),
        .off_volt_reg  (off_volt_reg),
        .on_curr_reg   (on_curr_reg),
        .on_volt_reg   (on_volt_reg),
        .off_ctrl_reg  (off_ctrl_reg)
    );

    // ------------------------------------------------------------------------
    // Limit selection helper
    // ------------------------------------------------------------------------
    // Picks one limit code; max override beats the user code
    function [7:0] pick_limit;
        input       on_now;
        input       mode_ok;
        input       fixed_en;
        input [7:0] on_code;
        input       off_max;
        input       off_code_en;
        input [7:0] off_code;
        input [7:0] dflt;
        begin
            if (on_now)
                pick_limit = (mode_ok && fixed_en) ? on_code : dflt;
            else if (off_max)
                pick_limit = `OPL_DAC_MAX;              // Caller qualifies the max mode
            else if (off_code_en && mode_ok)
                pick_limit = off_code;
            else
                pick_limit = `OPL_DAC_ZERO;
        end
    endfunction

    // ------------------------------------------------------------------------
    // Decoded settings
    // ------------------------------------------------------------------------
    wire cp_detect  = curr_prot_reg[`OPL_B_DETECT_EN];
    wire vp_detect  = volt_prot_reg[`OPL_B_DETECT_EN];
    wire cp_event   = cp_detect && curr_prot_hit;
    wire vp_event   = vp_detect && volt_prot_hit;
    wire cm_event   = current_mode && curr_meas_err;
    wire vm_event   = !current_mode && volt_meas_err;
    wire cm_msg     = cm_event && curr_prot_reg[`OPL_B_MEAS_MSG];
    wire vm_msg     = vm_event && volt_prot_reg[`OPL_B_MEAS_MSG];
    wire cp_queue   = cp_event && curr_prot_reg[`OPL_B_QUEUE_ERR];
    wire vp_queue   = vp_event && volt_prot_reg[`OPL_B_QUEUE_ERR];
    wire cp_off     = cp_event && curr_prot_reg[`OPL_B_PROT_OFF];
    wire vp_off     = vp_event && volt_prot_reg[`OPL_B_PROT_OFF];
    wire vm_off     = vm_msg && volt_prot_reg[`OPL_B_MEAS_OFF];
    wire cm_down    = cm_event && curr_prot_reg[`OPL_B_MEAS_OFF];
    wire cp_esr_en  = curr_prot_reg[`OPL_B_ESR_EN];

    // Event enable init value per current control byte
    wire [7:0] ese_init = (curr_prot_reg[`OPL_B_ESE_INIT] && cp_esr_en) ?
                          `OPL_ESE_WITH_CP : `OPL_ESE_PLAIN;

    // ------------------------------------------------------------------------
    // Error queue pulse and code
    // ------------------------------------------------------------------------
    // Current protect has priority; voltage one goes out the cycle after the last current one
    reg vp_pend_reg;
    always @(posedge clk)
    begin
        if (sys_rst)
        begin
            err_push    <= 1'b0;
            err_code    <= `OPL_ERR_NONE;
            vp_pend_reg <= 1'b0;
        end
        else if (cp_queue)
        begin
            err_push    <= 1'b1;
            err_code    <= `OPL_ERR_CURR_PROT;
            vp_pend_reg <= vp_queue | vp_pend_reg;
        end
        else if (vp_queue || vp_pend_reg)
        begin
            err_push    <= 1'b1;
            err_code    <= `OPL_ERR_VOLT_PROT;
            vp_pend_reg <= 1'b0;
        end
        else
        begin
            err_push    <= 1'b0;
            vp_pend_reg <= 1'b0;
        end
    end

    // ------------------------------------------------------------------------
    // Reactions
    // ------------------------------------------------------------------------
    // Device error message and output off requests, registered one cycle after the condition, high while it lasts
    always @(posedge clk)
    begin
        if (sys_rst)
        begin
            dev_err_push <= 1'b0;
            force_off    <= 1'b0;
        end
        else
        begin
            dev_err_push <= cm_msg | vm_msg;
            force_off    <= cp_off | vp_off | vm_off;
        end
    end

    // Shutdown latches until reset
    always @(posedge clk)
    begin
        if (sys_rst)
            shutdown <= 1'b0;
        else if (cm_down)
            shutdown <= 1'b1;
    end

    // ------------------------------------------------------------------------
    // Event status bit
    // ------------------------------------------------------------------------
    // Sticky current-protect bit; a new event wins over a clear
    always @(posedge clk)
    begin
        if (sys_rst)
            esr_curr_prot <= 1'b0;
        else if (cp_event && cp_esr_en)
            esr_curr_prot <= 1'b1;
        else if (esr_clear || !cp_esr_en)
            esr_curr_prot <= 1'b0;
    end

    // Enable-register init value, reloaded from the current control byte every cycle after reset
    always @(posedge clk)
    begin
        if (sys_rst)
        begin
            ese_reset_value <= `OPL_ESE_PLAIN;
            esr_cp_enabled  <= 1'b0;
        end
        else
        begin
            if (ese_load)
                ese_reset_value <= ese_init;
            else if (!curr_prot_reg[`OPL_B_ESE_INIT])
                ese_reset_value <= `OPL_ESE_PLAIN;
            else
                ese_reset_value <= ese_init;
            esr_cp_enabled <= cp_esr_en;
        end
    end

    // ------------------------------------------------------------------------
    // Limit DAC selection
    // ------------------------------------------------------------------------
    // Current limit in voltage mode, voltage limit in current mode
    always @(posedge clk)
    begin
        if (sys_rst)
        begin
            curr_limit_dac <= `OPL_DAC_ZERO;
            volt_limit_dac <= `OPL_DAC_ZERO;
        end
        else
        begin
            curr_limit_dac <= pick_limit(output_on, !current_mode,
                                         curr_prot_reg[`OPL_B_FIXED_LIMIT], on_curr_reg,
                                         off_ctrl_reg[`OPL_O_CURR_MAX] && current_mode,
                                         off_ctrl_reg[`OPL_O_CURR_CODE_EN],
                                         off_curr_reg, `OPL_DAC_MAX);
            volt_limit_dac <= pick_limit(output_on, current_mode,
                                         volt_prot_reg[`OPL_B_FIXED_LIMIT], on_volt_reg,
                                         off_ctrl_reg[`OPL_O_VOLT_MAX] && !current_mode,
                                         off_ctrl_reg[`OPL_O_VOLT_CODE_EN],
                                         off_volt_reg, `OPL_DAC_MAX);
        end
    end

endmodule

// *** test/opl_assertions.sv ***
// Assertion checker bound to the protection and limit block
`timescale 1ns/1ps
`include "opl_map.vh"
module opl_chk
(
    // Clock and reset
    input wire       clk,
    input wire       sys_rst,
    // Setting writes
    input wire       cfg_wr,
    input wire [2:0] cfg_sel,
    input wire [7:0] cfg_wdata,
    // Stage state and conditions
    input wire       output_on,
    input wire       current_mode,
    input wire       curr_prot_hit,
    input wire       volt_prot_hit,
    input wire       curr_meas_err,
    input wire       volt_meas_err,
    // Reactions
    input wire [7:0] ese_reset_value,
    input wire       esr_curr_prot,
    input wire       err_push,
    input wire [9:0] err_code,
    input wire       dev_err_push,
    input wire       force_off,
    input wire       shutdown,
    input wire [7:0] curr_limit_dac,
    input wire [7:0] volt_limit_dac
);
    reg  [7:0] sh_reg [0:6];
    integer    i;
    // Shadow copy of the stored settings, upper off-control bits dropped
    always @(posedge clk)
    begin
        if (sys_rst)
            for (i = 0; i < 7; i = i + 1)
                sh_reg[i] <= (i == 2 || i == 4) ? 8'h80 : 8'h00;
        else if (cfg_wr && cfg_sel != 3'h7)
            sh_reg[cfg_sel] <= (cfg_sel == `OPL_SEL_OFF_CTRL) ? {3'h0, cfg_wdata[4:0]} : cfg_wdata;
    end
    // Expected reactions from the shadow settings
    wire [7:0] cp     = sh_reg[0];
    wire [7:0] vp     = sh_reg[1];
    wire [7:0] oc     = sh_reg[6];
    wire       c_que  = curr_prot_hit & cp[6] & cp[3];
    wire       v_que  = volt_prot_hit & vp[6] & vp[3];
    wire       c_off  = curr_prot_hit & cp[6] & cp[2];
    wire       v_dev  = volt_meas_err & ~current_mode & vp[1];
    wire       v_off  = (volt_prot_hit & vp[6] & vp[2]) | (v_dev & vp[0]);
    wire       dev_q  = (curr_meas_err & current_mode & cp[1]) | v_dev;
    wire       c_shut = curr_meas_err & current_mode & cp[0];
    wire       ese_hi = cp[4] & cp[5];
    wire       esr_en = cp[5];
    wire [7:0] exp_c  = output_on ? ((~current_mode & cp[7]) ? sh_reg[4] : 8'hFF)
                      : (current_mode & oc[1]) ? 8'hFF : (~current_mode & oc[4]) ? sh_reg[2] : 8'h00;
    wire [7:0] exp_v  = output_on ? ((current_mode & vp[7]) ? sh_reg[5] : 8'hFF)
                      : (~current_mode & oc[0]) ? 8'hFF : (current_mode & oc[3]) ? sh_reg[3] : 8'h00;
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    AST_CURR_CODE: assert property (c_que |=> err_push && err_code == `OPL_ERR_CURR_PROT)
        else $error("current protect error not queued");
    AST_VOLT_CODE: assert property (v_que & ~c_que |=> err_push && err_code == `OPL_ERR_VOLT_PROT)
        else $error("voltage protect error not queued");
    AST_ERR_CAUSE: assert property ($rose(err_push) |-> $past(c_que) || $past(v_que))
        else $error("error queued without enabled detection");
    AST_CURR_OFF: assert property (c_off |=> force_off)
        else $error("current protect did not force off");
    AST_VOLT_OFF: assert property (v_off |=> force_off)
        else $error("voltage error did not force off");
    AST_DEV_ERR: assert property (##1 dev_err_push == $past(dev_q))
        else $error("device error pulse wrong");
    AST_SHUT_SET: assert property (c_shut |=> shutdown)
        else $error("shutdown not raised");
    AST_SHUT_HOLD: assert property (shutdown |=> shutdown)
        else $error("shutdown dropped before reset");
    AST_ESE_INIT: assert property (##1 ese_reset_value == ($past(ese_hi) ? 8'h48 : 8'h08))
        else $error("event enable init value wrong");
    AST_ESR_SET: assert property ($rose(esr_curr_prot) |-> $past(curr_prot_hit) && $past(esr_en))
        else $error("status bit set while not enabled");
    AST_CURR_DAC: assert property (##1 curr_limit_dac == $past(exp_c))
        else $error("current limit code wrong");
    AST_VOLT_DAC: assert property (##1 volt_limit_dac == $past(exp_v))
        else $error("voltage limit code wrong");
endmodule
bind opl_protect opl_chk u_chk (.clk, .sys_rst, .cfg_wr, .cfg_sel, .cfg_wdata, .output_on,
    .current_mode, .curr_prot_hit, .volt_prot_hit, .curr_meas_err, .volt_meas_err,
    .ese_reset_value, .esr_curr_prot, .err_push, .err_code, .dev_err_push, .force_off,
    .shutdown, .curr_limit_dac, .volt_limit_dac);

// *** test/opl_stage_model.sv ***
// Behavioural output stage that obeys the block's off requests
`timescale 1ns/1ps
module opl_stage_model
(
    // Clock and reset
    input  wire clk,
    input  wire sys_rst,
    // Host commands and block requests
    input  wire on_cmd,
    input  wire off_cmd,
    input  wire force_off,
    input  wire shutdown,
    // Stage state
    output reg  output_on
);
    // Any off request wins over an on command
    always @(posedge clk)
    begin
        if (sys_rst || off_cmd || force_off || shutdown)
            output_on <= 1'b0;
        else if (on_cmd)
            output_on <= 1'b1;
    end
endmodule

// *** test/tb_opl_protect.sv ***
// Self-checking bench for the protection and limit block
`timescale 1ns/1ps
`include "opl_map.vh"
module tb_opl_protect;
    reg        clk = 1'b0;
    reg        sys_rst = 1'b1;
    reg        cfg_wr = 1'b0;
    reg  [2:0] cfg_sel = 3'h0;
    reg  [7:0] cfg_wdata = 8'h00;
    reg  [2:0] cfg_rsel = 3'h0;
    reg        current_mode = 1'b0;
    reg        curr_prot_hit = 1'b0;
    reg        volt_prot_hit = 1'b0;
    reg        curr_meas_err = 1'b0;
    reg        volt_meas_err = 1'b0;
    reg        esr_clear = 1'b0;
    reg        ese_load = 1'b0;
    reg        on_cmd = 1'b0;
    reg        off_cmd = 1'b0;
    wire [7:0] cfg_rdata, ese_reset_value, curr_limit_dac, volt_limit_dac;
    wire [9:0] err_code;
    wire       output_on, esr_curr_prot, esr_cp_enabled, err_push, dev_err_push, force_off;
    wire       shutdown;
    integer    error_cnt = 0;
    integer    compares = 0;
    integer    k, n;
    reg        found;
    // Clock, design and output stage
    always #2 clk = ~clk;
    opl_protect dut (.clk, .sys_rst, .cfg_wr, .cfg_sel, .cfg_wdata, .cfg_rsel, .cfg_rdata,
        .output_on, .current_mode, .curr_prot_hit, .volt_prot_hit, .curr_meas_err,
        .volt_meas_err, .esr_clear, .ese_load, .ese_reset_value, .esr_curr_prot,
        .esr_cp_enabled, .err_push, .err_code, .dev_err_push, .force_off, .shutdown,
        .curr_limit_dac, .volt_limit_dac);
    opl_stage_model u_stage (.clk, .sys_rst, .on_cmd, .off_cmd, .force_off, .shutdown, .output_on);
    // Compare and count
    task check(input [9:0] seen, input [9:0] exp);
    begin
        compares = compares + 1;
        if (seen !== exp)
        begin
            error_cnt = error_cnt + 1;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    end
    endtask
    task wr(input [2:0] s, input [7:0] d);
    begin
        @(posedge clk);
        cfg_wr <= 1'b1;
        cfg_sel <= s;
        cfg_wdata <= d;
        @(posedge clk);
        cfg_wr <= 1'b0;
    end
    endtask
    task rd(input [2:0] s, input [7:0] exp);
    begin
        @(posedge clk);
        cfg_rsel <= s;
        repeat (2) @(posedge clk);
        #1 check({2'h0, cfg_rdata}, {2'h0, exp});
    end
    endtask
    // Bounded wait for a reaction: 0 queue, 1 device error, 2 force off, 3 status
    task wait_evt(input [1:0] w, output f);
    begin
        f = 1'b0;
        for (n = 0; n < 8 && !f; n = n + 1)
        begin
            @(posedge clk);
            #1 f = ((w == 0) ? err_push : (w == 1) ? dev_err_push : (w == 2) ? force_off
                   : esr_curr_prot) === 1'b1;
        end
    end
    endtask
    task set_out(input on, input md);
    begin
        @(posedge clk);
        on_cmd <= on;
        off_cmd <= !on;
        current_mode <= md;
        @(posedge clk);
        on_cmd <= 1'b0;
        off_cmd <= 1'b0;
        repeat (3) @(posedge clk);
        #1;
    end
    endtask
    task dac_case(input on, input md, input [7:0] c, input [7:0] v, input [7:0] o,
                  input [7:0] ec, input [7:0] ev);
    begin
        wr(`OPL_SEL_CURR_PROT, c);
        wr(`OPL_SEL_VOLT_PROT, v);
        wr(`OPL_SEL_OFF_CTRL, o);
        set_out(on, md);
        check({2'h0, curr_limit_dac}, {2'h0, ec});
        check({2'h0, volt_limit_dac}, {2'h0, ev});
    end
    endtask
    task done(input [8*8-1:0] name);
        $display("test %0s done", name);
    endtask
    task end_of_test;
    begin
        $display("compares %0d error_cnt %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    end
    endtask
    // Main sequence
    initial
    begin
        repeat (16) @(posedge clk);
        sys_rst <= 1'b0;
        for (k = 0; k < 8; k = k + 1)
            rd(k[2:0], (k == 2 || k == 4) ? 8'h80 : 8'h00);
        for (k = 0; k < 8; k = k + 1)
            wr(k[2:0], 8'hA5 ^ k[7:0]);
        for (k = 0; k < 8; k = k + 1)
            rd(k[2:0], (k == 7) ? 8'h00 : (k == 6) ? 8'h05 ^ k[7:0] : 8'hA5 ^ k[7:0]);
        done("regs");
        wr(`OPL_SEL_CURR_PROT, 8'h30);
        @(posedge clk) ese_load <= 1'b1;
        @(posedge clk) ese_load <= 1'b0;
        set_out(1'b0, 1'b0);
        check({2'h0, ese_reset_value}, 10'h048);
        check({9'h0, esr_cp_enabled}, 10'h001);
        wr(`OPL_SEL_CURR_PROT, 8'h10);
        set_out(1'b0, 1'b0);
        check({2'h0, ese_reset_value}, 10'h008);
        done("ese");
        wr(`OPL_SEL_CURR_PROT, 8'h4C);
        set_out(1'b1, 1'b0);
        @(posedge clk) curr_prot_hit <= 1'b1;
        wait_evt(2'h0, found);
        check({9'h0, found}, 10'h001);
        check(err_code, `OPL_ERR_CURR_PROT);
        check({9'h0, force_off}, 10'h001);
        @(posedge clk) curr_prot_hit <= 1'b0;
        repeat (3) @(posedge clk);
        #1 check({9'h0, output_on}, 10'h000);
        check({9'h0, esr_curr_prot}, 10'h000);
        wr(`OPL_SEL_CURR_PROT, 8'h0C);
        @(posedge clk) curr_prot_hit <= 1'b1;
        wait_evt(2'h0, found);
        check({9'h0, found}, 10'h000);
        wr(`OPL_SEL_CURR_PROT, 8'h60);
        wait_evt(2'h3, found);
        check({9'h0, found}, 10'h001);
        @(posedge clk) curr_prot_hit <= 1'b0;
        @(posedge clk) esr_clear <= 1'b1;
        @(posedge clk) esr_clear <= 1'b0;
        set_out(1'b0, 1'b0);
        check({9'h0, esr_curr_prot}, 10'h000);
        done("curprot");
        wr(`OPL_SEL_VOLT_PROT, 8'h4C);
        @(posedge clk) volt_prot_hit <= 1'b1;
        wait_evt(2'h0, found);
        check({9'h0, found}, 10'h001);
        check(err_code, `OPL_ERR_VOLT_PROT);
        check({9'h0, force_off}, 10'h001);
        @(posedge clk) volt_prot_hit <= 1'b0;
        done("voltprot");
        wr(`OPL_SEL_CURR_PROT, 8'h02);
        set_out(1'b0, 1'b1);
        @(posedge clk) curr_meas_err <= 1'b1;
        wait_evt(2'h1, found);
        check({9'h0, found}, 10'h001);
        set_out(1'b0, 1'b0);
        wait_evt(2'h1, found);
        check({9'h0, found}, 10'h000);
        @(posedge clk) curr_meas_err <= 1'b0;
        wr(`OPL_SEL_VOLT_PROT, 8'h03);
        @(posedge clk) volt_meas_err <= 1'b1;
        wait_evt(2'h1, found);
        check({9'h0, found}, 10'h001);
        check({9'h0, force_off}, 10'h001);
        @(posedge clk) volt_meas_err <= 1'b0;
        done("deverr");
        wr(`OPL_SEL_CURR_PROT, 8'h01);
        set_out(1'b1, 1'b1);
        @(posedge clk) curr_meas_err <= 1'b1;
        @(posedge clk) curr_meas_err <= 1'b0;
        set_out(1'b1, 1'b1);
        check({9'h0, shutdown}, 10'h001);
        check({9'h0, output_on}, 10'h000);
        @(posedge clk) sys_rst <= 1'b1;
        repeat (16) @(posedge clk);
        sys_rst <= 1'b0;
        set_out(1'b0, 1'b0);
        check({9'h0, shutdown}, 10'h000);
        done("shutdown");
        wr(`OPL_SEL_OFF_CURR, 8'h55);
        wr(`OPL_SEL_OFF_VOLT, 8'h66);
        wr(`OPL_SEL_ON_CURR, 8'h33);
        wr(`OPL_SEL_ON_VOLT, 8'h44);
        dac_case(1'b1, 1'b0, 8'h80, 8'h00, 8'h00, 8'h33, 8'hFF);
        dac_case(1'b1, 1'b1, 8'h00, 8'h80, 8'h00, 8'hFF, 8'h44);
        dac_case(1'b1, 1'b1, 8'h80, 8'h00, 8'h00, 8'hFF, 8'hFF);
        dac_case(1'b0, 1'b0, 8'h00, 8'h00, 8'h10, 8'h55, 8'h00);
        dac_case(1'b0, 1'b1, 8'h00, 8'h00, 8'h08, 8'h00, 8'h66);
        dac_case(1'b0, 1'b0, 8'h00, 8'h00, 8'h01, 8'h00, 8'hFF);
        dac_case(1'b0, 1'b1, 8'h00, 8'h00, 8'h02, 8'hFF, 8'h00);
        dac_case(1'b0, 1'b0, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00);
        done("limits");
        end_of_test;
    end
endmodule
